// ==== rtl/slil_defines.vh ====
// constants for the serial link init and lock block
`ifndef SLIL_DEFINES_VH
`define SLIL_DEFINES_VH

`define SLIL_DATA_W          24
`define SLIL_FRAME_BITS      28
`define SLIL_FRAME_LAST      5'h1B
`define SLIL_CLK_HALF        5'h0E
`define SLIL_POS_HIGH        0
`define SLIL_POS_DATA_LO     1
`define SLIL_POS_DATA_HI     24
`define SLIL_POS_INVERT      25
`define SLIL_POS_CHECK       26
`define SLIL_POS_LOW         27
`define SLIL_FIFO_DEPTH      8
`define SLIL_FIFO_AW         3
`define SLIL_TX_LOCK_EDGES   8'h10
`define SLIL_RX_LOCK_FRAMES  8'h04
`define SLIL_LFSR_SEED       24'hACE1F5
`define SLIL_HALF_WORD       8'h18

`endif

// ==== rtl/slil_link_top.v ====
// serial link with embedded clock: framer, lock acquisition and word buffer
//
// Functional notes
// - 24-bit word per transmit clock, one serial stream
// - serial data DC-balanced by selective inversion
// - deserializer rebuilds 24-bit word and recovered clock
// - transmit clock 5 to 35 MHz, source supplied
// - lock from stream alone, any data pattern
// - embedded clock monitored, lock flag raised on lock
// - serializer locks first, then deserializer synchronizes
// - outputs off until supply reaches 2.2V
// - serial output off while serializer PLL locks
// - parallel and clock outputs off while locking
// - lock flag low until locked to stream
// - random non-repeating words sent while the word buffer is empty
// - recover bit clock, re-time coded incoming data
// - find rising embedded edge, validate integrity, lock
// - lock flag rises with first valid output word
// - frame: 24 data plus four overhead bits
// - edge select picks rising or falling strobe
// - output enable low floats outputs, lock kept
// - one missed embedded edge drops lock, rehunt
`timescale 1ns/10ps
`include "slil_defines.vh"

module slil_fifo #(
  parameter W     = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire           clk,
  input  wire           rst_b,
  input  wire           flush,
  input  wire [W-1:0]   inData,
  input  wire           inValid,
  output wire           inReady,
  output wire [W-1:0]   outData,
  output wire           outValid,
  input  wire           outReady
);
  reg  [W-1:0]  mem [0:DEPTH-1];
  reg  [AW-1:0] wrPtr_reg;
  reg  [AW-1:0] rdPtr_reg;
  reg  [AW:0]   count_reg;
  wire          doPush;
  wire          doPop;

  assign inReady  = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_reg];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  always @(posedge clk)
  begin
    if (doPush)
      mem[wrPtr_reg] <= inData;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doPush)
        wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (doPop)
        rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      count_reg <= count_reg + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
    end
  end
endmodule // slil_fifo

module slil_link_top #(
  parameter [7:0] RX_LOCK_FRAMES = `SLIL_RX_LOCK_FRAMES
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        supply_ok,
  input  wire        transmit_clock,
  input  wire [23:0] tx_parallel_in,
  output reg         txReady_reg,
  output reg         serialOut_reg,
  output reg         serialOutEn_reg,
  input  wire        serial_input_pair,
  input  wire        rx_strobe_edge_select,
  input  wire        rxOutEnable,
  output reg  [23:0] rx_parallel_out,
  output reg         rxParallelOutEn_reg,
  output reg         rxClkOut_reg,
  output reg         rxClkOutEn_reg,
  output reg         lockFlag_reg
);
  localparam [2:0] TX_OFF  = 3'b001;
  localparam [2:0] TX_LOCK = 3'b010;
  localparam [2:0] TX_RUN  = 3'b100;
  localparam [2:0] RX_HUNT = 3'b001;
  localparam [2:0] RX_ACQ  = 3'b010;
  localparam [2:0] RX_LOCK = 3'b100;

  function [4:0] ones24;
    input [23:0] v;
    integer i;
    begin
      ones24 = 5'h00;
      for (i = 0; i < 24; i = i + 1)
        ones24 = ones24 + {4'h0, v[i]};
    end
  endfunction

  function frame_chk;
    input        inv;
    input [23:0] v;
    frame_chk = ^{inv, v};
  endfunction

  // input synchronisers
  reg        supS1_reg, supS2_reg;
  reg        tclkS1_reg, tclkS2_reg, tclkPrev_reg;
  reg [23:0] txDS1_reg, txDS2_reg;
  reg        rxS1_reg, rxS2_reg, rxPrev_reg;
  reg        selS1_reg, selS2_reg;
  reg        oenS1_reg, oenS2_reg;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {supS2_reg, supS1_reg}                 <= 2'b00;
      {tclkPrev_reg, tclkS2_reg, tclkS1_reg} <= 3'b000;
      {txDS2_reg, txDS1_reg}                 <= 48'h000000000000;
      {rxPrev_reg, rxS2_reg, rxS1_reg}       <= 3'b000;
      {selS2_reg, selS1_reg}                 <= 2'b00;
      {oenS2_reg, oenS1_reg}                 <= 2'b00;
    end
    else
    begin
      {supS2_reg, supS1_reg}                 <= {supS1_reg, supply_ok};
      {tclkPrev_reg, tclkS2_reg, tclkS1_reg} <= {tclkS2_reg, tclkS1_reg, transmit_clock};
      {txDS2_reg, txDS1_reg}                 <= {txDS1_reg, tx_parallel_in};
      {rxPrev_reg, rxS2_reg, rxS1_reg}       <= {rxS2_reg, rxS1_reg, serial_input_pair};
      {selS2_reg, selS1_reg}                 <= {selS1_reg, rx_strobe_edge_select};
      {oenS2_reg, oenS1_reg}                 <= {oenS1_reg, rxOutEnable};
    end
  end

  wire powerGood = supS2_reg;
  wire tclkRise  = tclkS2_reg & ~tclkPrev_reg;

  // serializer
  reg  [2:0]  txState_reg;
  reg  [7:0]  txEdgeCnt_reg;
  reg  [4:0]  txBitCnt_reg;
  reg  [27:0] txShift_reg;
  reg  [23:0] lfsr_reg;
  reg  signed [7:0] disp_reg;
  wire        txRun = (txState_reg == TX_RUN);
  wire        frameLoad = txRun & (txBitCnt_reg == `SLIL_FRAME_LAST);
  wire        fifoInReady;
  wire [23:0] fifoData;
  wire        fifoValid;

  // word taken on each synchronised transmit clock rising edge in TX_RUN while the buffer has room; the 5..35 MHz
  // source rate is the sender's duty, the frame timing runs on ref_clk
  slil_fifo #(
    .W     (`SLIL_DATA_W),
    .DEPTH (`SLIL_FIFO_DEPTH),
    .AW    (`SLIL_FIFO_AW)
  ) txFifo (
    .clk      (ref_clk),
    .rst_b    (rst_b),
    .flush    (~txRun),
    .inData   (txDS2_reg),
    .inValid  (tclkRise & txRun),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (frameLoad)
  );

  // idle frames carry scrambler words, never a fixed pattern
  wire [23:0] lfsrNext = {lfsr_reg[22:0], lfsr_reg[23] ^ lfsr_reg[22] ^ lfsr_reg[21] ^ lfsr_reg[16]};
  wire [23:0] txWord   = fifoValid ? fifoData : lfsr_reg;
  wire signed [7:0] wordDisp = $signed({2'b00, ones24(txWord), 1'b0}) - $signed(`SLIL_HALF_WORD);
  wire        txInv    = (disp_reg >= 8'sd0) ? (wordDisp > 8'sd0) : (wordDisp < 8'sd0);
  wire [23:0] txSent   = txInv ? ~txWord : txWord;
  wire signed [7:0] dispNext = txInv ? (disp_reg - wordDisp) : (disp_reg + wordDisp);
  wire [27:0] txFrame  = {1'b0, frame_chk(txInv, txSent), txInv, txSent, 1'b1};

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txState_reg     <= TX_OFF;
      txEdgeCnt_reg   <= 8'h00;
      txBitCnt_reg    <= 5'h00;
      txShift_reg     <= 28'h0000000;
      lfsr_reg        <= `SLIL_LFSR_SEED;
      disp_reg        <= 8'sd0;
      serialOut_reg   <= 1'b0;
      serialOutEn_reg <= 1'b0;
      txReady_reg     <= 1'b0;
    end
    else if (!powerGood)
    begin
      txState_reg     <= TX_OFF;
      txEdgeCnt_reg   <= 8'h00;
      txBitCnt_reg    <= 5'h00;
      serialOut_reg   <= 1'b0;
      serialOutEn_reg <= 1'b0;
      txReady_reg     <= 1'b0;
    end
    else
    begin
      case (txState_reg)
        TX_OFF: txState_reg <= TX_LOCK;
        TX_LOCK:
        begin
          if (tclkRise)
          begin
            txEdgeCnt_reg <= txEdgeCnt_reg + 8'h01;
            if (txEdgeCnt_reg == `SLIL_TX_LOCK_EDGES - 8'h01)
            begin
              txState_reg  <= TX_RUN;
              txBitCnt_reg <= `SLIL_FRAME_LAST;
            end
          end
        end
        TX_RUN:
        begin
          if (frameLoad)
          begin
            txShift_reg  <= txFrame;
            txBitCnt_reg <= 5'h00;
            disp_reg     <= dispNext;
            if (!fifoValid)
              lfsr_reg <= lfsrNext;
          end
          else
          begin
            txShift_reg  <= {1'b0, txShift_reg[27:1]};
            txBitCnt_reg <= txBitCnt_reg + 5'h01;
          end
        end
        default: txState_reg <= TX_OFF;
      endcase
      serialOut_reg   <= frameLoad ? txFrame[0] : txShift_reg[1];
      serialOutEn_reg <= txRun;
      txReady_reg     <= txRun & fifoInReady;
    end
  end

  // deserializer: one serial bit per ref_clk, re-timed by the synchroniser
  reg  [2:0]  rxState_reg;
  reg  [4:0]  rxBitCnt_reg;
  reg  [27:0] rxShift_reg;
  reg  [7:0]  goodCnt_reg;
  reg  [23:0] pendWord_reg;
  reg         pendValid_reg;
  wire [27:0] rxVec   = {rxS2_reg, rxShift_reg[27:1]};
  wire        rxAlign = (rxState_reg != RX_HUNT);
  wire        rxDone  = rxAlign & (rxBitCnt_reg == `SLIL_FRAME_LAST);
  wire        edgeOk  = rxVec[`SLIL_POS_HIGH] & ~rxVec[`SLIL_POS_LOW];
  wire [23:0] rxData  = rxVec[`SLIL_POS_DATA_HI:`SLIL_POS_DATA_LO];
  wire        rxInv   = rxVec[`SLIL_POS_INVERT];
  wire        chkOk   = (frame_chk(rxInv, rxData) == rxVec[`SLIL_POS_CHECK]);
  wire [23:0] rxWord  = rxInv ? ~rxData : rxData;
  wire [4:0]  cntNext = rxDone ? 5'h00 : rxBitCnt_reg + 5'h01;
  wire        strobe  = selS2_reg ? (cntNext == 5'h00) : (cntNext == `SLIL_CLK_HALF);
  wire        lostEdge = (rxState_reg == RX_LOCK) & rxDone & ~edgeOk;
  wire        lockNext = (rxState_reg == RX_LOCK) & ~lostEdge & (lockFlag_reg | (strobe & pendValid_reg));
  wire        outEnNext = lockNext & oenS2_reg;

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxState_reg         <= RX_HUNT;
      rxBitCnt_reg        <= 5'h00;
      rxShift_reg         <= 28'h0000000;
      goodCnt_reg         <= 8'h00;
      pendWord_reg        <= 24'h000000;
      pendValid_reg       <= 1'b0;
      rx_parallel_out     <= 24'h000000;
      rxParallelOutEn_reg <= 1'b0;
      rxClkOut_reg        <= 1'b0;
      rxClkOutEn_reg      <= 1'b0;
      lockFlag_reg        <= 1'b0;
    end
    else if (!powerGood)
    begin
      rxState_reg         <= RX_HUNT;
      goodCnt_reg         <= 8'h00;
      pendValid_reg       <= 1'b0;
      rxParallelOutEn_reg <= 1'b0;
      rxClkOutEn_reg      <= 1'b0;
      rxClkOut_reg        <= 1'b0;
      lockFlag_reg        <= 1'b0;
    end
    else
    begin
      rxShift_reg <= rxVec;
      case (rxState_reg)
        RX_HUNT:
        begin
          goodCnt_reg   <= 8'h00;
          pendValid_reg <= 1'b0;
          // low-to-high step marks a frame start; no training word needed
          if (!rxPrev_reg && rxS2_reg)
          begin
            rxState_reg  <= RX_ACQ;
            rxBitCnt_reg <= 5'h01;
          end
        end
        RX_ACQ:
        begin
          rxBitCnt_reg <= cntNext;
          if (rxDone)
          begin
            if (edgeOk && chkOk)
            begin
              goodCnt_reg <= goodCnt_reg + 8'h01;
              if (goodCnt_reg >= RX_LOCK_FRAMES - 8'h01)
              begin
                rxState_reg   <= RX_LOCK;
                pendWord_reg  <= rxWord;
                pendValid_reg <= 1'b1;
              end
            end
            else
              rxState_reg <= RX_HUNT;
          end
        end
        RX_LOCK:
        begin
          rxBitCnt_reg <= cntNext;
          if (lostEdge)
            rxState_reg <= RX_HUNT;
          else if (rxDone && chkOk)
          begin
            pendWord_reg  <= rxWord;
            pendValid_reg <= 1'b1;
          end
        end
        default: rxState_reg <= RX_HUNT;
      endcase
      if (lockNext && strobe)
        rx_parallel_out <= pendWord_reg;
      lockFlag_reg        <= lockNext;
      rxClkOut_reg        <= lockNext & (cntNext < `SLIL_CLK_HALF);
      rxParallelOutEn_reg <= outEnNext;
      rxClkOutEn_reg      <= outEnNext;
    end
  end
endmodule // slil_link_top

// ==== verification/slil_host_model.sv ====
// host model: transmit clock and counting word source
`timescale 1ns/10ps
module slil_host_model #(
  parameter [23:0] STEP = 24'h010203
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  output reg         transmit_clock,
  output reg  [23:0] tx_parallel_in
);
  reg [4:0] phaseCnt;
  // one word per 28 ref_clk cycles, the fastest the framer drains
  always @(negedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      phaseCnt       <= 5'h00;
      transmit_clock <= 1'b0;
      tx_parallel_in <= 24'h000000;
    end
    else
    begin
      phaseCnt <= (phaseCnt == 5'h1B) ? 5'h00 : phaseCnt + 5'h01;
      if (phaseCnt == 5'h0D)
        transmit_clock <= 1'b1;
      if (phaseCnt == 5'h1B)
      begin
        transmit_clock <= 1'b0;
        // data moves half a period away from the strobing rise
        tx_parallel_in <= tx_parallel_in + STEP;
      end
    end
endmodule // slil_host_model

// ==== verification/slil_link_chk.sv ====
// assertions on the serial link top ports
`timescale 1ns/10ps
module slil_link_chk #(
  parameter [7:0] RX_LOCK_FRAMES = 8'h04
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic supply_ok,
  input wire logic rxOutEnable,
  input wire logic txReady_reg,
  input wire logic serialOut_reg,
  input wire logic serialOutEn_reg,
  input wire logic rxParallelOutEn_reg,
  input wire logic rxClkOut_reg,
  input wire logic rxClkOutEn_reg,
  input wire logic lockFlag_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // first frame: high bit, 26 payload bits, low bit, next high bit
  sequence frame_ends;
    serialOut_reg ##27 !serialOut_reg ##1 serialOut_reg;
  endsequence
  sequence supply_gone;
    !supply_ok [*3];
  endsequence
  // enable pin low long enough to pass the synchroniser and the output flop
  sequence oe_held_low;
    !rxOutEnable [*4];
  endsequence
  rx_en_lock_a: assert property (rxParallelOutEn_reg |-> lockFlag_reg)
    else $error("outputs enabled while unlocked");
  clk_en_same_a: assert property (rxClkOutEn_reg == rxParallelOutEn_reg)
    else $error("clock and data enables differ");
  clk_idle_a: assert property (!lockFlag_reg && !$past(lockFlag_reg) |-> !rxClkOut_reg)
    else $error("recovered clock runs while unlocked");
  supply_hold_a: assert property (supply_gone |=> !serialOutEn_reg && !lockFlag_reg && !txReady_reg)
    else $error("outputs active without supply");
  oe_float_a: assert property (oe_held_low |-> !rxParallelOutEn_reg && !rxClkOutEn_reg)
    else $error("outputs enabled while enable pin low");
  frame_edge_a: assert property ($rose(serialOutEn_reg) |-> frame_ends)
    else $error("embedded clock bits wrong");
  lock_order_a: assert property ($rose(lockFlag_reg) |-> serialOutEn_reg)
    else $error("lock before serializer runs");
  rclk_width_a: assert property ($rose(rxClkOut_reg) && lockFlag_reg |-> ##13 (rxClkOut_reg || !lockFlag_reg))
    else $error("recovered clock high phase short");
  ready_run_a: assert property (txReady_reg |-> serialOutEn_reg || $past(serialOutEn_reg))
    else $error("ready while serializer off");
endmodule // slil_link_chk

bind slil_link_top slil_link_chk #(.RX_LOCK_FRAMES(RX_LOCK_FRAMES)) chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .supply_ok(supply_ok), .rxOutEnable(rxOutEnable), .txReady_reg(txReady_reg),
  .serialOut_reg(serialOut_reg), .serialOutEn_reg(serialOutEn_reg),
  .rxParallelOutEn_reg(rxParallelOutEn_reg), .rxClkOut_reg(rxClkOut_reg),
  .rxClkOutEn_reg(rxClkOutEn_reg), .lockFlag_reg(lockFlag_reg));

// ==== verification/test_serdes_link_init_lock.sv ====
// testbench for the serial link init and lock block
`timescale 1ns/10ps
module test_serdes_link_init_lock;
  localparam [23:0] STEP = 24'h010203;
  reg         ref_clk, rst_b, supply_ok, rx_strobe_edge_select, rxOutEnable, breakLink, idleBit;
  wire        transmit_clock, serial_input_pair, txReady_reg, serialOut_reg, serialOutEn_reg;
  wire        rxParallelOutEn_reg, rxClkOut_reg, rxClkOutEn_reg, lockFlag_reg;
  wire [23:0] tx_parallel_in, rx_parallel_out;
  integer     num_errors, n_tests, cycleCnt;

  // loopback; a released line toggles instead of holding its last level
  assign serial_input_pair = breakLink ? 1'b0 : (serialOutEn_reg ? serialOut_reg : idleBit);

  slil_host_model #(.STEP(STEP)) host_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .transmit_clock(transmit_clock), .tx_parallel_in(tx_parallel_in));
  slil_link_top #(.RX_LOCK_FRAMES(8'h04)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .supply_ok(supply_ok), .transmit_clock(transmit_clock), .tx_parallel_in(tx_parallel_in),
    .txReady_reg(txReady_reg), .serialOut_reg(serialOut_reg), .serialOutEn_reg(serialOutEn_reg),
    .serial_input_pair(serial_input_pair), .rx_strobe_edge_select(rx_strobe_edge_select),
    .rxOutEnable(rxOutEnable), .rx_parallel_out(rx_parallel_out),
    .rxParallelOutEn_reg(rxParallelOutEn_reg), .rxClkOut_reg(rxClkOut_reg),
    .rxClkOutEn_reg(rxClkOutEn_reg), .lockFlag_reg(lockFlag_reg));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // starts from a known level even if the first edge meets an unset value
  always @(negedge ref_clk)
    idleBit <= (idleBit === 1'b1) ? 1'b0 : 1'b1;

  task stop_test;
  begin
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  always @(posedge ref_clk)
  begin
    cycleCnt = cycleCnt + 1;
    if (cycleCnt == 20000)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t run hung", $time);
      stop_test;
    end
  end

  task check_bit(input logic got, input logic exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  end
  endtask

  task check_word(input logic [23:0] got, input logic [23:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  end
  endtask

  task wait_lock(input logic lvl);
    integer i;
  begin
    for (i = 0; i < 3000 && lockFlag_reg !== lvl; i++)
      @(negedge ref_clk);
  end
  endtask

  task t_power_up;
    integer i;
  begin
    supply_ok = 1'b0;
    repeat (200) @(negedge ref_clk);
    check_bit(serialOutEn_reg, 1'b0);
    check_bit(lockFlag_reg, 1'b0);
    supply_ok = 1'b1;
    for (i = 0; i < 3000 && serialOutEn_reg !== 1'b1; i++)
      @(negedge ref_clk);
    check_bit(i >= 400, 1'b1);
    check_bit(serialOutEn_reg, 1'b1);
    check_bit(lockFlag_reg, 1'b0);
    check_bit(rxParallelOutEn_reg, 1'b0);
    wait_lock(1'b1);
    check_bit(lockFlag_reg, 1'b1);
    repeat (2) @(negedge ref_clk);
    check_bit(rxParallelOutEn_reg, 1'b1);
    check_bit(txReady_reg, 1'b1);
  end
  endtask

  task t_words(input logic sel);
    logic [23:0] prev;
    integer      k, n;
  begin
    rx_strobe_edge_select = sel;
    repeat (60) @(negedge ref_clk);
    prev = rx_parallel_out;
    n = 0;
    for (k = 0; k < 400 && n < 6; k++)
    begin
      @(negedge ref_clk);
      if (rx_parallel_out !== prev && lockFlag_reg === 1'b1)
      begin
        check_bit(rxClkOut_reg, sel);
        if (n > 0)
          check_word(rx_parallel_out, prev + STEP);
        prev = rx_parallel_out;
        n = n + 1;
      end
    end
    check_bit(n == 6, 1'b1);
  end
  endtask

  task t_out_enable;
  begin
    rxOutEnable = 1'b0;
    repeat (10) @(negedge ref_clk);
    check_bit(rxParallelOutEn_reg, 1'b0);
    check_bit(rxClkOutEn_reg, 1'b0);
    check_bit(lockFlag_reg, 1'b1);
    rxOutEnable = 1'b1;
    repeat (60) @(negedge ref_clk);
    check_bit(rxParallelOutEn_reg, 1'b1);
  end
  endtask

  task t_relock;
  begin
    breakLink = 1'b1;
    repeat (60) @(negedge ref_clk);
    check_bit(lockFlag_reg, 1'b0);
    check_bit(rxParallelOutEn_reg, 1'b0);
    breakLink = 1'b0;
    wait_lock(1'b1);
    check_bit(lockFlag_reg, 1'b1);
  end
  endtask

  initial
  begin
    rst_b = 1'b0;
    supply_ok = 1'b0;
    rx_strobe_edge_select = 1'b1;
    rxOutEnable = 1'b1;
    breakLink = 1'b0;
    num_errors = 0;
    n_tests = 0;
    cycleCnt = 0;
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    t_power_up;
    t_words(1'b1);
    t_words(1'b0);
    t_out_enable;
    t_relock;
    t_words(1'b1);
    stop_test;
  end
endmodule // test_serdes_link_init_lock
